// *** pll_clock_ratio_control.sv ***
/*
 * Register file and cycle-level model of a fractional-N PLL clock path:
 * reference prescale, ratio N.K, fixed divide by 4, source select and the
 * system clock divider, with a clock output for the general purpose pin.
 * Assumes ref_tick marks one reference clock edge, synchronous to mclk and
 * slow enough that the modelled PLL rate stays below the mclk rate.
 */
`timescale 1ns/1ns
`include "pll_clock_ratio_control_defines.svh"

module pll_clock_ratio_control (
   // Clock and reset
   input  wire logic                                      mclk,
   input  wire logic                                      srst,
   // Control word port
   input  wire logic                                      wr_en,
   input  wire logic                                      rd_en,
   input  wire pll_clock_ratio_control_pkg::control_word_t ctrl,
   output logic [8:0]                                     rdata,
   // Reference clock edge marker
   input  wire logic                                      ref_tick,
   // Clock and status outputs
   output logic                                           pll_tick,
   output logic                                           system_clock_tick,
   output logic                                           gpio_clk,
   output pll_clock_ratio_control_pkg::pll_status_t       status
);

   localparam int CW = 8 + `CREDIT_FRACTION_BITS;

   logic [8:0]       power_management_one;
   logic [8:0]       clock_generation;
   logic [8:0]       pll_integer_ratio;
   logic [8:0]       pll_fraction_high;
   logic [8:0]       pll_fraction_mid;
   logic [8:0]       pll_fraction_low;
   logic [CW-1:0]    credit;
   logic [1:0]       quarter_count;
   logic             quarter_tick;
   logic [4:0]       sysdiv_acc;

   // Half-unit thresholds so that 1.5 and the rest share one counter
   function automatic logic [4:0] sysdiv_threshold(input logic [2:0] sel);
      logic [4:0] t;
      t = 5'h02;
      unique case (sel)
         3'h0: t = 5'h02;
         3'h1: t = 5'h03;
         3'h2: t = 5'h04;
         3'h3: t = 5'h06;
         3'h4: t = 5'h08;
         3'h5: t = 5'h0c;
         3'h6: t = 5'h10;
         3'h7: t = 5'h18;
      endcase
      return t;
   endfunction : sysdiv_threshold

   // Ratio in Q4.24 scaled into the Q6.26 credit step
   function automatic logic [31:0] prescaled_step(
      input pll_clock_ratio_control_pkg::input_prescale_select_t sel,
      input logic [27:0] ratio);
      logic [31:0] s;
      s = 32'h0;
      unique case (sel)
         pll_clock_ratio_control_pkg::PRESCALE_TIMES_2:
            s = {1'b0, ratio, 3'b000};
         pll_clock_ratio_control_pkg::PRESCALE_PASS:
            s = {2'b00, ratio, 2'b00};
         pll_clock_ratio_control_pkg::PRESCALE_DIV_2:
            s = {3'b000, ratio, 1'b0};
         pll_clock_ratio_control_pkg::PRESCALE_DIV_4:
            s = {4'b0000, ratio};
      endcase
      return s;
   endfunction : prescaled_step

   // Decode
   wire hit_power = ctrl.addr == `OFS_POWER_MANAGEMENT_ONE;
   wire hit_clock = ctrl.addr == `OFS_CLOCK_GENERATION;
   wire hit_int   = ctrl.addr == `OFS_PLL_INTEGER_RATIO;
   wire hit_high  = ctrl.addr == `OFS_PLL_FRACTION_HIGH;
   wire hit_mid   = ctrl.addr == `OFS_PLL_FRACTION_MID;
   wire hit_low   = ctrl.addr == `OFS_PLL_FRACTION_LOW;

   wire [8:0] next_rdata =
      hit_power ? power_management_one :
      hit_clock ? clock_generation :
      hit_int   ? pll_integer_ratio :
      hit_high  ? pll_fraction_high :
      hit_mid   ? pll_fraction_mid :
      hit_low   ? pll_fraction_low : 9'h000;

   // Enables
   wire pll_on_bit    = power_management_one[`BIT_PLL_ON];
   wire [1:0] midrail_select =
      power_management_one[`MSB_MIDRAIL:`LSB_MIDRAIL];
   wire pll_power_off = pll_integer_ratio[`BIT_PLL_POWER_OFF];
   wire fraction_enable = pll_integer_ratio[`BIT_FRACTION_ENABLE];
   wire pll_run = pll_on_bit && (midrail_select != 2'b00)
                  && !pll_power_off;

   // Ratio word
   wire [3:0] integer_ratio_field =
      pll_integer_ratio[`MSB_INTEGER_RATIO:`LSB_INTEGER_RATIO];
   wire [23:0] fraction_word = {pll_fraction_high[`MSB_FRACTION_HIGH:0],
                                pll_fraction_mid,
                                pll_fraction_low};
   // Dropping K models the modulator switched off
   wire [23:0] used_fraction = fraction_enable ? fraction_word
                                               : 24'h000000;
   wire [27:0] ratio = {integer_ratio_field, used_fraction};

   wire pll_clock_ratio_control_pkg::input_prescale_select_t prescale =
      pll_clock_ratio_control_pkg::input_prescale_select_t'(
         pll_integer_ratio[`MSB_PRESCALE:`LSB_PRESCALE]);
   wire [31:0] step = prescaled_step(prescale, ratio);

   // Credit of owed PLL output cycles; saturates rather than wraps
   wire whole_cycle = credit[CW-1:`CREDIT_FRACTION_BITS] != 8'h00;
   wire room        = credit[CW-1:CW-2] != 2'b11;
   wire [CW-1:0] add_step = (ref_tick && room) ? {2'b00, step}
                                                : {CW{1'b0}};
   wire [CW-1:0] take_one = whole_cycle
                          ? {8'h01, {`CREDIT_FRACTION_BITS{1'b0}}}
                          : {CW{1'b0}};
   wire [CW-1:0] next_credit = pll_run ? credit + add_step - take_one
                                       : {CW{1'b0}};

   // Source select and system divider
   wire clock_source_select = clock_generation[`BIT_CLOCK_SOURCE];
   wire src_tick = clock_source_select ? quarter_tick : ref_tick;
   wire [4:0] threshold = sysdiv_threshold(
      clock_generation[`MSB_SYSDIV:`LSB_SYSDIV]);
   wire [4:0] acc_plus = sysdiv_acc + 5'h02;
   wire sys_edge = src_tick && (acc_plus >= threshold);
   wire [4:0] next_sysdiv_acc = !src_tick ? sysdiv_acc
                              : sys_edge ? acc_plus - threshold
                              : acc_plus;

   // Register file
   always_ff @(posedge mclk) begin
      if (srst) begin
         power_management_one <= `RST_POWER_MANAGEMENT_ONE;
         clock_generation     <= `RST_CLOCK_GENERATION;
         pll_integer_ratio    <= `RST_PLL_INTEGER_RATIO;
         pll_fraction_high    <= `RST_PLL_FRACTION_HIGH;
         pll_fraction_mid     <= `RST_PLL_FRACTION_MID;
         pll_fraction_low     <= `RST_PLL_FRACTION_LOW;
      end else if (wr_en) begin
         if (hit_power) power_management_one <= ctrl.wdata;
         if (hit_clock) clock_generation     <= ctrl.wdata;
         if (hit_int)   pll_integer_ratio    <= ctrl.wdata;
         if (hit_high)  pll_fraction_high    <= {3'b000, ctrl.wdata[5:0]};
         if (hit_mid)   pll_fraction_mid     <= ctrl.wdata;
         if (hit_low)   pll_fraction_low     <= ctrl.wdata;
      end
   end

   sequence write_integer_s;
      wr_en && hit_int;
   endsequence

   AST_MIDRAIL_HOLDS: assert property (
      @(posedge mclk) disable iff (srst)
      midrail_select == 2'b00 |=> !status.running)
      else $error("PLL running with midrail select 00");

   AST_RATIO_WORD: assert property (
      @(posedge mclk) disable iff (srst)
      fraction_enable |=> status.fraction_word == $past(fraction_word)
                          && status.integer_ratio_field
                             == $past(pll_integer_ratio[3:0]))
      else $error("Status ratio differs from programmed ratio");

   AST_FRACTION_OFF: assert property (
      @(posedge mclk) disable iff (srst)
      !fraction_enable |=> status.fraction_word == 24'h000000)
      else $error("Fraction used while fraction_enable is clear");

   AST_INTEGER_WRITE: assert property (
      @(posedge mclk) disable iff (srst)
      write_integer_s |=> integer_ratio_field == $past(ctrl.wdata[3:0])
                          && prescale == $past(ctrl.wdata[5:4]))
      else $error("Integer ratio register did not take the write");

   // Same-cycle write must not leak into the read value
   AST_READ_INTEGER: assert property (
      @(posedge mclk) disable iff (srst)
      rd_en && hit_int |=> rdata == $past(pll_integer_ratio))
      else $error("Integer ratio register read back wrong");

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata <= 9'h000;
      end else if (rd_en) begin
         rdata <= next_rdata;
      end
   end

   // PLL model and fixed divide by 4
   always_ff @(posedge mclk) begin
      if (srst) begin
         credit        <= {CW{1'b0}};
         pll_tick      <= 1'b0;
         quarter_count <= 2'd0;
         quarter_tick  <= 1'b0;
      end else begin
         credit       <= next_credit;
         pll_tick     <= pll_run && whole_cycle;
         quarter_tick <= pll_tick && quarter_count == `PLL_FIXED_DIVIDE;
         if (pll_tick) begin
            quarter_count <= quarter_count + 2'd1;
         end
      end
   end

   sequence pll_idle_s;
      !pll_run ##1 !pll_run;
   endsequence

   AST_OFF_NO_TICK: assert property (
      @(posedge mclk) disable iff (srst)
      !pll_on_bit |=> !pll_tick)
      else $error("PLL tick while pll_on_bit is clear");

   AST_POWER_DOWN: assert property (
      @(posedge mclk) disable iff (srst)
      pll_power_off |=> !pll_tick && !status.running)
      else $error("PLL active while powered down");

   AST_FIXED_QUARTER: assert property (
      @(posedge mclk) disable iff (srst)
      quarter_tick |-> $past(pll_tick) && $past(quarter_count) == 2'd3)
      else $error("Quarter tick without fourth PLL tick");

   AST_CREDIT_DRAIN: assert property (
      @(posedge mclk) disable iff (srst)
      pll_run && whole_cycle |=> pll_tick)
      else $error("Owed PLL cycle not issued");

   AST_IDLE_CLEARS: assert property (
      @(posedge mclk) disable iff (srst)
      pll_idle_s |-> credit == {CW{1'b0}} && !pll_tick)
      else $error("PLL model active while disabled");

   // System clock and pin clock
   always_ff @(posedge mclk) begin
      if (srst) begin
         sysdiv_acc  <= 5'h00;
         system_clock_tick <= 1'b0;
         gpio_clk    <= 1'b0;
         status      <= '0;
      end else begin
         sysdiv_acc  <= next_sysdiv_acc;
         system_clock_tick <= sys_edge;
         if (sys_edge) begin
            gpio_clk <= !gpio_clk;
         end
         status <= {pll_run, integer_ratio_field, used_fraction};
      end
   end

   AST_SOURCE_RAW: assert property (
      @(posedge mclk) disable iff (srst)
      !clock_source_select && ref_tick && threshold == 5'h02
      |=> system_clock_tick)
      else $error("Raw reference not passed at divide by 1");

   // Raw reference edges must not leak through while the PLL is selected
   AST_PLL_SOURCE: assert property (
      @(posedge mclk) disable iff (srst)
      clock_source_select && !quarter_tick |=> !system_clock_tick)
      else $error("System clock tick without PLL quarter tick");

   AST_SYSTEM_CLOCK_CAUSE: assert property (
      @(posedge mclk) disable iff (srst)
      system_clock_tick |-> $past(src_tick))
      else $error("System clock tick without source tick");

   AST_GPIO_TOGGLE: assert property (
      @(posedge mclk) disable iff (srst)
      system_clock_tick |-> gpio_clk != $past(gpio_clk))
      else $error("Pin clock did not toggle on system clock tick");

   AST_DIV_THREE: assert property (
      @(posedge mclk) disable iff (srst)
      threshold == 5'h06 && sysdiv_acc == 5'h04 && src_tick
      |=> system_clock_tick)
      else $error("Divide by 3 missed its output tick");

endmodule : pll_clock_ratio_control

// *** pll_clock_ratio_control_defines.svh ***
/*
 * Register offsets, field positions, reset values and fixed ratios of the
 * PLL clock ratio control block.
 * Assumes it is included by bare name wherever the block's numbers are used.
 */
`ifndef PLL_CLOCK_RATIO_CONTROL_DEFINES_SVH
`define PLL_CLOCK_RATIO_CONTROL_DEFINES_SVH

// Register offsets (7-bit control word address)
`define OFS_POWER_MANAGEMENT_ONE 7'h01
`define OFS_CLOCK_GENERATION     7'h06
`define OFS_PLL_INTEGER_RATIO    7'h24
`define OFS_PLL_FRACTION_HIGH    7'h25
`define OFS_PLL_FRACTION_MID     7'h26
`define OFS_PLL_FRACTION_LOW     7'h27

// Reset values
`define RST_POWER_MANAGEMENT_ONE 9'h000
`define RST_CLOCK_GENERATION     9'h140
`define RST_PLL_INTEGER_RATIO    9'h048
`define RST_PLL_FRACTION_HIGH    9'h00c
`define RST_PLL_FRACTION_MID     9'h093
`define RST_PLL_FRACTION_LOW     9'h0e9

// Field positions
`define BIT_PLL_ON               5
`define MSB_MIDRAIL              1
`define LSB_MIDRAIL              0
`define BIT_PLL_POWER_OFF        7
`define BIT_FRACTION_ENABLE      6
`define MSB_PRESCALE             5
`define LSB_PRESCALE             4
`define MSB_INTEGER_RATIO        3
`define LSB_INTEGER_RATIO        0
`define BIT_CLOCK_SOURCE         8
`define MSB_SYSDIV               7
`define LSB_SYSDIV               5
`define MSB_FRACTION_HIGH        5

// Fixed post divider after the PLL
`define PLL_FIXED_DIVIDE         2'd3
// Fraction width of the ratio word and of the credit accumulator
`define FRACTION_BITS            24
`define CREDIT_FRACTION_BITS     26

`endif

// *** pll_clock_ratio_control_pkg.sv ***
/*
 * Types of the PLL clock ratio control block.
 * Assumes the defines header supplies the numbers.
 */
package pll_clock_ratio_control_pkg;

   typedef enum logic [1:0] {
      PRESCALE_TIMES_2,
      PRESCALE_PASS,
      PRESCALE_DIV_2,
      PRESCALE_DIV_4
   } input_prescale_select_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [8:0] wdata;
   } control_word_t;

   typedef struct packed {
      logic       running;
      logic [3:0] integer_ratio_field;
      logic [23:0] fraction_word;
   } pll_status_t;

endpackage : pll_clock_ratio_control_pkg

// *** ref_clock_source.sv ***
/*
 * Reference clock source model: one-cycle ref_tick markers on request.
 * Assumes the bench raises fire for one cycle with count and gap set.
 */
`timescale 1ns/1ns
module ref_clock_source (
   // Clock
   input  wire logic       mclk,
   // Request
   input  wire logic       fire,
   input  wire logic [7:0] count,
   input  wire logic [3:0] gap,
   // Reference edge marker
   output logic            ref_tick = 1'b0
);
   logic [7:0] left   = 8'h00;
   logic [3:0] wait_c = 4'h0;
   // Falling edge keeps the marker clear of the sampling edge
   always @(negedge mclk) begin
      ref_tick <= 1'b0;
      if (fire) begin
         left   <= count;
         wait_c <= 4'h0;
      end else if (left != 8'h00) begin
         if (wait_c == 4'h0) begin
            ref_tick <= 1'b1;
            left     <= left - 8'h01;
            wait_c   <= gap;
         end else begin
            wait_c <= wait_c - 4'h1;
         end
      end
   end
endmodule : ref_clock_source

// *** tb_pll_clock_ratio_control.sv ***
/*
 * Self-checking bench: register access, run gating, prescale, ratio,
 * fixed divide and system clock divider, counted at the tick outputs.
 * Assumes the register port contract and reset values of the hand-over.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   error_cnt++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb_pll_clock_ratio_control;
   logic       mclk = 1'b0;
   logic       srst = 1'b1;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       fire = 1'b0;
   logic [7:0] count = 8'h00;
   logic [3:0] gap = 4'h0;
   logic [8:0] rdata;
   logic       ref_tick, pll_tick, system_clock_tick, gpio_clk, gpio_q;
   pll_clock_ratio_control_pkg::control_word_t ctrl = '0;
   pll_clock_ratio_control_pkg::pll_status_t   status;
   int error_cnt = 0, n_checks = 0, cnt_pll, cnt_sys, cnt_gpio;
   int div24 [8] = '{24, 16, 12, 8, 6, 4, 3, 2};
   logic [6:0] ra [7] = '{7'h01, 7'h06, 7'h24, 7'h25, 7'h26, 7'h27, 7'h30};
   logic [8:0] rv [7] = '{9'h000, 9'h140, 9'h048, 9'h00c, 9'h093, 9'h0e9,
                          9'h000};
   logic [8:0] rn [6] = '{9'h000, 9'h021, 9'h020, 9'h022, 9'h003, 9'h023};

   pll_clock_ratio_control dut (.mclk(mclk), .srst(srst), .wr_en(wr_en),
      .rd_en(rd_en), .ctrl(ctrl), .rdata(rdata), .ref_tick(ref_tick),
      .pll_tick(pll_tick), .system_clock_tick(system_clock_tick), .gpio_clk(gpio_clk),
      .status(status));
   ref_clock_source src (.mclk(mclk), .fire(fire), .count(count),
      .gap(gap), .ref_tick(ref_tick));

   initial forever #5 mclk = ~mclk;

   // Pulses counted on the sampling edge, before that edge's updates land
   always @(posedge mclk) begin
      cnt_pll += int'(pll_tick);
      cnt_sys += int'(system_clock_tick);
      if (gpio_clk !== gpio_q) cnt_gpio++;
      gpio_q = gpio_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic rst();
      srst = 1'b1;
      repeat (20) @(negedge mclk);
      srst = 1'b0;
   endtask : rst

   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      ctrl  = {a, d};
      wr_en = 1'b1;
      @(negedge mclk);
      wr_en = 1'b0;
      // Idle cycle so a following strobe is not raised in the same step
      @(negedge mclk);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [8:0] ex);
      ctrl.addr = a;
      rd_en     = 1'b1;
      @(negedge mclk);
      rd_en = 1'b0;
      `CHK("rdata", ex, rdata)
      @(negedge mclk);
   endtask : rd

   // Fire n reference edges gap+1 cycles apart, then wait cyc cycles
   task automatic run(input logic [7:0] n, input logic [3:0] g, input int cyc);
      cnt_pll  = 0;
      cnt_sys  = 0;
      cnt_gpio = 0;
      count    = n;
      gap      = g;
      fire    <= 1'b1;
      @(negedge mclk);
      fire    <= 1'b0;
      repeat (cyc) @(negedge mclk);
   endtask : run

   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      stop_test();
   end

   initial begin
      rst();
      for (int i = 0; i < 7; i++)
         rd(ra[i], rv[i]);
      wr(7'h30, 9'h1ff);
      rd(7'h30, 9'h000);
      wr(7'h25, 9'h1ff);
      wr(7'h26, 9'h155);
      wr(7'h27, 9'h0aa);
      rd(7'h25, 9'h03f);
      `CHK("fraction", {6'h3f, 9'h155, 9'h0aa}, status.fraction_word)
      `CHK("integer", 4'h8, status.integer_ratio_field)
      wr(7'h24, 9'h008);
      repeat (2) @(negedge mclk);
      `CHK("fraction off", 24'h000000, status.fraction_word)
      $display("test registers done");
      // Gating: each running case follows a stopped one, clearing credit
      rst();
      for (int i = 0; i < 6; i++) begin
         wr(7'h01, rn[i]);
         run(8'd1, 4'd1, 30);
         `CHK("running", rn[i][5] & |rn[i][1:0], status.running)
         `CHK("pll ticks", (rn[i][5] & |rn[i][1:0]) ? 16 : 0, cnt_pll)
      end
      wr(7'h24, 9'h0c8);
      run(8'd1, 4'd1, 30);
      `CHK("powered off", 0, cnt_pll)
      `CHK("powered off run", 1'b0, status.running)
      $display("test gating done");
      rst();
      wr(7'h01, 9'h023);
      for (int p = 0; p < 4; p++) begin
         wr(7'h24, {3'b000, p[1:0], 4'h8});
         run(8'd1, 4'd1, 30);
         `CHK("prescale", 16 >> p, cnt_pll)
      end
      $display("test prescale done");
      // 5 edges x2 at 8.192 owe 81.92 cycles; integer only owes 80
      for (int f = 0; f < 2; f++) begin
         rst();
         wr(7'h01, 9'h023);
         if (f == 0) begin
            wr(7'h24, 9'h008);
         end else begin
            wr(7'h24, 9'h048);
            wr(7'h25, 9'h00c);
            wr(7'h26, 9'h093);
            wr(7'h27, 9'h0e9);
         end
         run(8'd5, 4'd15, 120);
         `CHK("ratio", f ? 81 : 80, cnt_pll)
         `CHK("system_clock", 10, cnt_sys)
         `CHK("gpio", 10, cnt_gpio)
      end
      $display("test ratio done");
      for (int d = 0; d < 8; d++) begin
         rst();
         wr(7'h06, {1'b0, d[2:0], 5'h00});
         run(8'd24, 4'd3, 110);
         `CHK("divider", div24[d], cnt_sys)
         `CHK("gpio div", div24[d], cnt_gpio)
      end
      $display("test divider done");
      stop_test();
   end
endmodule : tb_pll_clock_ratio_control
